// ### spf_pkg.sv
// Constants and types for the serial flash command sequencer.
package spf_pkg;
  localparam logic [7:0] OP_READ = 8'h03;
  localparam logic [7:0] OP_FAST = 8'h0b;
  localparam logic [7:0] OP_DUAL = 8'h3b;
  localparam logic [7:0] OP_PROG = 8'h02;
  localparam logic [7:0] OP_SE = 8'h20;
  localparam logic [7:0] OP_BE32 = 8'h52;
  localparam logic [7:0] OP_BE64 = 8'hd8;
  localparam logic [7:0] OP_WREN = 8'h06;
  localparam logic [7:0] OP_WRDI = 8'h04;
  localparam logic [7:0] OP_RDSR = 8'h05;
  localparam logic [7:0] OP_WRSR = 8'h01;
  localparam logic [4:0] ADDR_LAST = 5'h17;
  localparam logic [4:0] DUMMY_LAST = 5'h07;
  localparam logic [4:0] BYTE_LAST = 5'h07;
  localparam logic [4:0] DUAL_LAST = 5'h03;
  localparam int PAGE_BYTES = 256;
  localparam int SE_AW = 12;
  localparam int BE32_AW = 15;
  localparam int BE64_AW = 16;
  localparam int PROT_LOG0 = 15;
  localparam int SR_BUSY = 0;
  localparam int SR_WEL = 1;
  localparam int SR_BP = 2;
  localparam int SR_TB = 5;
  localparam int SR_LOCK = 7;
  localparam logic [7:0] SR_WMASK = 8'hbc;
  localparam logic [7:0] SR_RESET = 8'h00;
  localparam logic [7:0] ERASED = 8'hff;
  localparam int PP_CYC = 512;
  localparam int WSR_CYC = 1024;
  localparam int SE_CYC = 8192;
  localparam int BE32_CYC = 65536;
  localparam int BE64_CYC = 131072;
  typedef enum logic [2:0] {
    ST_OPC, ST_ADDR, ST_DUMMY, ST_RDATA, ST_PDATA, ST_SRW, ST_END, ST_SKIP
  } spf_state_t;
  typedef enum logic [1:0] {EX_NONE, EX_PROG, EX_ERASE, EX_WSR} spf_exec_t;
endpackage

// ### spf_flash_seq.sv
// Serial flash read, program and erase command sequencer.
`timescale 1ns/1ns
// Contract
// - Opcode and 24-bit address sampled on rising edges.
// - Read data shifted out MSB first on falling edges.
// - Read address increments after every byte.
// - Chip select high stops output and ends read.
// - Array reads while busy are ignored completely.
// - Fast read adds eight ignored dummy clocks.
// - Dual read sends two bits per clock.
// - Program and erase need write-enable latch set.
// - Page program takes address then up to 256 bytes.
// - Program address wraps inside the current page.
// - Extra program bytes overwrite earlier buffered bytes.
// - Execute only if select rises on byte boundary.
// - Valid program or erase sets busy until done.
// - Status reads still answered during busy cycles.
// - Finished cycle clears the write-enable latch.
// - Program to protected page is refused.
// - Sector erase fills aligned 4K sector with FFh.
// - 32K block erase fills aligned 32K block.
// - 64K block erase fills aligned 64K block.
// - Erase refused when the base of its aligned block is protected.
// - Write-enable opcode sets the latch.
// - Only status bits 7,5,4,3,2 are writable.
// - Status read accepted at any time.
module spf_flash_seq #(
  parameter int MEM_AW = 21,
  parameter int PP_CYCLES = spf_pkg::PP_CYC,
  parameter int WSR_CYCLES = spf_pkg::WSR_CYC,
  parameter int SE_CYCLES = spf_pkg::SE_CYC,
  parameter int BE32_CYCLES = spf_pkg::BE32_CYC,
  parameter int BE64_CYCLES = spf_pkg::BE64_CYC
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic cs_n,
  input wire logic sclk,
  input wire logic serial_data_bidir_in,
  input wire logic write_protect_n,
  output logic serial_data_out,
  output logic serial_data_out_oe,
  output logic serial_data_bidir_out,
  output logic serial_data_bidir_oe,
  output logic [7:0] status
);
  import spf_pkg::*;

  localparam int MEM_BYTES = 1 << MEM_AW;

  // ********************
  // Pin synchronisers
  // ********************
  logic cs_m, cs_s, cs_d, ck_m, ck_s, ck_d, di_m, di_s, wp_m, wp_s;
  logic rise, fall, cs_up;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cs_m <= 1'b1;
      cs_s <= 1'b1;
      cs_d <= 1'b1;
      ck_m <= 1'b0;
      ck_s <= 1'b0;
      ck_d <= 1'b0;
      di_m <= 1'b0;
      di_s <= 1'b0;
      wp_m <= 1'b1;
      wp_s <= 1'b1;
    end else begin
      cs_m <= cs_n;
      cs_s <= cs_m;
      cs_d <= cs_s;
      ck_m <= sclk;
      ck_s <= ck_m;
      ck_d <= ck_s;
      di_m <= serial_data_bidir_in;
      di_s <= di_m;
      wp_m <= write_protect_n;
      wp_s <= wp_m;
    end
  end

  assign rise = ck_s & ~ck_d & ~cs_s;
  assign fall = ~ck_s & ck_d & ~cs_s;
  assign cs_up = cs_s & ~cs_d;

  // ********************
  // Command state
  // ********************
  spf_state_t st, next_st;
  spf_exec_t ex, next_ex;
  logic [7:0] opc, next_opc, sh, next_sh, osh, next_osh, next_status;
  logic [4:0] bcnt, next_bcnt, last_bit;
  logic [23:0] addr, next_addr, wa, next_wa, addr_p1, addr_in, esz, ebase;
  logic [16:0] wleft, next_wleft;
  logic [17:0] tmr, next_tmr, etmr;
  logic [PAGE_BYTES-1:0] pmask, next_pmask;
  logic pgot, next_pgot, next_so, next_so_oe, next_sio, next_sio_oe;
  logic [7:0] opc_in, byte_in, mem_wd, pb_wd;
  logic [MEM_AW-1:0] mem_wa;
  logic [7:0] pb_wa;
  logic mem_we, pb_we, at_end, is_erase, write_enable_latch;
  logic go_prog, go_erase, go_wsr;
  logic [7:0] mem [MEM_BYTES];
  logic [7:0] pbuf [PAGE_BYTES];

  // Protected when the address falls in the range chosen by the bp bits.
  function automatic logic prot(input logic [23:0] a);
    logic [31:0] sz;
    logic [31:0] off;
    sz = 32'h1 << (PROT_LOG0 + int'(status[SR_BP+:3]));
    off = 32'(a[MEM_AW-1:0]);
    if (status[SR_BP+:3] == 3'h0) begin
      prot = 1'b0;
    end else if (sz >= 32'(MEM_BYTES)) begin
      prot = 1'b1;
    end else if (status[SR_TB]) begin
      prot = off < sz;
    end else begin
      prot = off >= 32'(MEM_BYTES) - sz;
    end
  endfunction

  assign opc_in = {opc[6:0], di_s};
  assign byte_in = {sh[6:0], di_s};
  assign addr_in = {addr[22:0], di_s};
  assign addr_p1 = addr + 24'h1;
  assign write_enable_latch = status[SR_WEL];
  assign last_bit = (opc == OP_DUAL) ? DUAL_LAST : BYTE_LAST;
  assign is_erase = opc == OP_SE || opc == OP_BE32 || opc == OP_BE64;
  assign esz = (opc == OP_SE) ? 24'h1 << SE_AW :
    (opc == OP_BE32) ? 24'h1 << BE32_AW : 24'h1 << BE64_AW;
  assign ebase = addr & ~(esz - 24'h1);
  assign etmr = (opc == OP_SE) ? 18'(SE_CYCLES) :
    (opc == OP_BE32) ? 18'(BE32_CYCLES) : 18'(BE64_CYCLES);
  assign at_end = cs_up && st == ST_END;
  assign go_erase = at_end && is_erase && write_enable_latch && !prot(ebase);
  assign go_prog = cs_up && st == ST_PDATA && bcnt == 5'h0 && pgot &&
    write_enable_latch && !prot(addr);
  assign go_wsr = at_end && opc == OP_WRSR && write_enable_latch &&
    !(status[SR_LOCK] && !wp_s);

  always_comb begin
    next_st = st;
    next_opc = opc;
    next_sh = sh;
    next_bcnt = bcnt;
    next_addr = addr;
    next_osh = osh;
    next_so = serial_data_out;
    next_so_oe = serial_data_out_oe;
    next_sio = serial_data_bidir_out;
    next_sio_oe = serial_data_bidir_oe;
    next_status = status;
    next_pgot = pgot;
    next_pmask = pmask;
    next_ex = ex;
    next_wa = wa;
    next_wleft = wleft;
    next_tmr = tmr;
    mem_we = 1'b0;
    mem_wa = wa[MEM_AW-1:0];
    mem_wd = ERASED;
    pb_we = 1'b0;
    pb_wa = addr[7:0];
    pb_wd = byte_in;
    if (cs_s) begin
      next_st = ST_OPC;
      next_bcnt = 5'h0;
      next_so_oe = 1'b0;
      next_sio_oe = 1'b0;
      if (at_end && opc == OP_WREN) begin
        next_status[SR_WEL] = 1'b1;
      end
      if (at_end && opc == OP_WRDI) begin
        next_status[SR_WEL] = 1'b0;
      end
      if (go_prog) begin
        next_ex = EX_PROG;
        next_wa = {addr[23:8], 8'h00};
        next_wleft = 17'(PAGE_BYTES);
        next_tmr = 18'(PP_CYCLES);
        next_status[SR_BUSY] = 1'b1;
      end
      if (go_erase) begin
        next_ex = EX_ERASE;
        next_wa = ebase;
        next_wleft = esz[16:0];
        next_tmr = etmr;
        next_status[SR_BUSY] = 1'b1;
      end
      if (go_wsr) begin
        next_ex = EX_WSR;
        next_wleft = 17'h0;
        next_tmr = 18'(WSR_CYCLES);
        next_status[SR_BUSY] = 1'b1;
      end
    end else if (rise) begin
      next_bcnt = bcnt + 5'h1;
      case (st)
        ST_OPC: begin
          next_opc = opc_in;
          if (bcnt == BYTE_LAST) begin
            next_bcnt = 5'h0;
            if (status[SR_BUSY] && opc_in != OP_RDSR) begin
              next_st = ST_SKIP;
            end else begin
              case (opc_in)
                OP_READ, OP_FAST, OP_DUAL, OP_PROG, OP_SE, OP_BE32,
                OP_BE64: next_st = ST_ADDR;
                OP_RDSR: begin
                  next_st = ST_RDATA;
                  next_osh = status;
                end
                OP_WRSR: next_st = ST_SRW;
                OP_WREN, OP_WRDI: next_st = ST_END;
                default: next_st = ST_SKIP;
              endcase
            end
          end
        end
        ST_ADDR: begin
          next_addr = addr_in;
          if (bcnt == ADDR_LAST) begin
            next_bcnt = 5'h0;
            if (opc == OP_FAST || opc == OP_DUAL) begin
              next_st = ST_DUMMY;
            end else if (opc == OP_READ) begin
              next_st = ST_RDATA;
              next_osh = mem[addr_in[MEM_AW-1:0]];
            end else if (opc == OP_PROG) begin
              next_st = ST_PDATA;
              next_pmask = '0;
              next_pgot = 1'b0;
            end else begin
              next_st = ST_END;
            end
          end
        end
        ST_DUMMY: begin
          if (bcnt == DUMMY_LAST) begin
            next_bcnt = 5'h0;
            next_st = ST_RDATA;
            next_osh = mem[addr[MEM_AW-1:0]];
          end
        end
        ST_PDATA: begin
          next_sh = byte_in;
          if (bcnt == BYTE_LAST) begin
            next_bcnt = 5'h0;
            pb_we = 1'b1;
            next_pmask[addr[7:0]] = 1'b1;
            next_addr[7:0] = addr[7:0] + 8'h1;
            next_pgot = 1'b1;
          end
        end
        ST_SRW: begin
          next_sh = byte_in;
          if (bcnt == BYTE_LAST) begin
            next_bcnt = 5'h0;
            next_st = ST_END;
          end
        end
        ST_END: next_st = ST_SKIP;
        default: next_bcnt = bcnt;
      endcase
    end else if (fall && st == ST_RDATA) begin
      next_so_oe = 1'b1;
      next_so = osh[7];
      next_bcnt = bcnt + 5'h1;
      if (opc == OP_DUAL) begin
        next_sio = osh[6];
        next_sio_oe = 1'b1;
        next_osh = {osh[5:0], 2'b00};
      end else begin
        next_osh = {osh[6:0], 1'b0};
      end
      if (bcnt == last_bit) begin
        next_bcnt = 5'h0;
        if (opc == OP_RDSR) begin
          next_osh = status;
        end else begin
          next_addr = addr_p1;
          next_osh = mem[addr_p1[MEM_AW-1:0]];
        end
      end
    end
    if (ex != EX_NONE) begin
      if (tmr != 18'h0) begin
        next_tmr = tmr - 18'h1;
      end
      if (wleft != 17'h0) begin
        next_wa = wa + 24'h1;
        next_wleft = wleft - 17'h1;
        if (ex == EX_PROG) begin
          mem_we = pmask[wa[7:0]];
          mem_wd = pbuf[wa[7:0]];
        end else begin
          mem_we = 1'b1;
        end
      end else if (tmr == 18'h0) begin
        next_ex = EX_NONE;
        next_status[SR_BUSY] = 1'b0;
        next_status[SR_WEL] = 1'b0;
        if (ex == EX_WSR) begin
          next_status = sh & SR_WMASK;
        end
      end
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st <= ST_OPC;
      ex <= EX_NONE;
      opc <= 8'h00;
      sh <= 8'h00;
      osh <= 8'h00;
      bcnt <= 5'h0;
      addr <= 24'h0;
      wa <= 24'h0;
      wleft <= 17'h0;
      tmr <= 18'h0;
      pmask <= '0;
      pgot <= 1'b0;
      status <= SR_RESET;
      serial_data_out <= 1'b0;
      serial_data_out_oe <= 1'b0;
      serial_data_bidir_out <= 1'b0;
      serial_data_bidir_oe <= 1'b0;
    end else begin
      st <= next_st;
      ex <= next_ex;
      opc <= next_opc;
      sh <= next_sh;
      osh <= next_osh;
      bcnt <= next_bcnt;
      addr <= next_addr;
      wa <= next_wa;
      wleft <= next_wleft;
      tmr <= next_tmr;
      pmask <= next_pmask;
      pgot <= next_pgot;
      status <= next_status;
      serial_data_out <= next_so;
      serial_data_out_oe <= next_so_oe;
      serial_data_bidir_out <= next_sio;
      serial_data_bidir_oe <= next_sio_oe;
    end
  end

  // Array and page buffer hold no reset, as in the real cell array.
  always_ff @(posedge clk) begin
    if (mem_we) begin
      mem[mem_wa] <= mem_wd;
    end
    if (pb_we) begin
      pbuf[pb_wa] <= pb_wd;
    end
  end

  // ********************
  // Checks
  // ********************
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_n);

  sequence s_opc_done;
    rise && st == ST_OPC && bcnt == BYTE_LAST;
  endsequence
  sequence s_addr_done;
    rise && st == ST_ADDR && bcnt == ADDR_LAST && opc == OP_READ;
  endsequence

  busy_ignore_a: assert property (
    s_opc_done ##0 (status[SR_BUSY] && opc_in != OP_RDSR) |=> st == ST_SKIP)
    else $error("command taken while busy");
  rdsr_take_a: assert property (
    s_opc_done ##0 (opc_in == OP_RDSR) |=> st == ST_RDATA &&
    osh == $past(status)) else $error("status read not taken");
  read_start_a: assert property (
    s_addr_done |=> st == ST_RDATA && addr == $past(addr_in))
    else $error("read address not taken");
  out_release_a: assert property (
    cs_s |=> !serial_data_out_oe && !serial_data_bidir_oe)
    else $error("output driven after deselect");
  dummy_hold_a: assert property (
    rise && st == ST_DUMMY && bcnt != DUMMY_LAST |=> st == ST_DUMMY)
    else $error("dummy phase cut short");
  dual_pins_a: assert property (
    fall && st == ST_RDATA && opc == OP_DUAL |=> serial_data_bidir_oe &&
    serial_data_out == $past(osh[7]) && serial_data_bidir_out ==
    $past(osh[6])) else $error("dual output bits wrong");
  read_incr_a: assert property (
    fall && st == ST_RDATA && opc == OP_READ && bcnt == BYTE_LAST |=>
    addr == $past(addr_p1)) else $error("read address not advanced");
  page_wrap_a: assert property (
    rise && st == ST_PDATA && bcnt == BYTE_LAST |=>
    addr[23:8] == $past(addr[23:8]) && pgot)
    else $error("page address left the page");
  wel_gate_a: assert property (
    at_end && is_erase && !write_enable_latch |=> ex == EX_NONE && !status[SR_BUSY])
    else $error("erase ran without write enable");
  partial_drop_a: assert property (
    cs_up && st == ST_PDATA && bcnt != 5'h0 |=> !status[SR_BUSY])
    else $error("partial byte program ran");
  prog_busy_a: assert property (
    go_prog |=> status[SR_BUSY] && ex == EX_PROG)
    else $error("program did not raise busy");
  wel_clear_a: assert property (
    $fell(status[SR_BUSY]) |-> !status[SR_WEL])
    else $error("latch not cleared after cycle");
  prot_prog_a: assert property (
    cs_up && st == ST_PDATA && prot(addr) |=> !status[SR_BUSY])
    else $error("protected page programmed");
  erase_fill_a: assert property (
    ex == EX_ERASE && wleft != 17'h0 |-> mem_we && mem_wd == ERASED)
    else $error("erase wrote wrong value");
endmodule // spf_flash_seq

// ### spf_host.sv
// Host SPI master model that drives the flash sequencer pins.
`timescale 1ns/1ns
module spf_host (
  input wire logic clk,
  input wire logic so,
  input wire logic bidir_oe,
  input wire logic bidir_out,
  output logic cs_n,
  output logic sclk,
  output logic line,
  output logic rx_stb,
  output logic [7:0] rx_data
);
  logic mosi;
  logic drive;
  logic dual;
  logic cap;
  logic tog;
  initial begin
    cs_n = 1'b1;
    sclk = 1'b0;
    mosi = 1'b0;
    drive = 1'b1;
    dual = 1'b0;
    cap = 1'b0;
    tog = 1'b0;
    rx_stb = 1'b0;
    rx_data = 8'h00;
  end
  // ****
  // Shared data line.
  // ****
  // A released line toggles so that no stale bit can pass as data.
  always @(posedge clk) tog <= !tog;
  assign line = bidir_oe ? bidir_out : (drive ? mosi : tog);
  task automatic open_f();
    @(negedge clk);
    cs_n = 1'b0;
    repeat (4) @(negedge clk);
  endtask
  // Bits change with the falling clock and are read before the rise.
  task automatic xb(input logic [7:0] tx, input int n);
    logic [7:0] rx;
    rx = 8'h00;
    for (int i = 0; i < n; i++) begin
      sclk = 1'b0;
      mosi = tx[7-i];
      drive = !dual;
      repeat (5) @(negedge clk);
      rx = dual ? {rx[5:0], so, line} : {rx[6:0], so};
      sclk = 1'b1;
      repeat (3) @(negedge clk);
    end
    if (cap) begin
      rx_data = rx;
      rx_stb = 1'b1;
      @(negedge clk);
      rx_stb = 1'b0;
    end
  endtask
  task automatic close_f();
    sclk = 1'b0;
    repeat (4) @(negedge clk);
    cs_n = 1'b1;
    dual = 1'b0;
    drive = 1'b1;
    repeat (6) @(negedge clk);
  endtask
endmodule // spf_host

// ### spf_flash_seq_test.sv
// Self-checking bench for the serial flash command sequencer.
`timescale 1ns/1ns
module spf_flash_seq_test;
  import spf_pkg::*;
  logic clk;
  logic rst_n;
  logic write_protect_n;
  logic [31:0] seed = 32'h00011303;
  logic [7:0] d[258];
  logic [7:0] exp_q[$];
  int error_cnt = 0;
  int comparisons = 0;
  wire logic cs_n;
  wire logic sclk;
  wire logic line;
  wire logic so;
  wire logic so_oe;
  wire logic bo;
  wire logic b_oe;
  wire logic stb;
  wire logic [7:0] rxd;
  wire logic [7:0] status;
  spf_flash_seq #(.MEM_AW(16), .PP_CYCLES(1),
    .SE_CYCLES(1), .BE32_CYCLES(1), .BE64_CYCLES(1)) i_dut (
    .clk(clk), .rst_n(rst_n), .cs_n(cs_n), .sclk(sclk),
    .serial_data_bidir_in(line), .write_protect_n(write_protect_n),
    .serial_data_out(so), .serial_data_out_oe(so_oe),
    .serial_data_bidir_out(bo), .serial_data_bidir_oe(b_oe),
    .status(status));
  spf_host i_host (.clk(clk), .so(so), .bidir_oe(b_oe), .bidir_out(bo),
    .cs_n(cs_n), .sclk(sclk), .line(line), .rx_stb(stb), .rx_data(rxd));
  initial begin
    clk = 1'b0;
    forever #20 clk = !clk;
  end
  // ****
  // Helpers.
  // ****
  function automatic logic [7:0] rnd();
    seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
    return seed[7:0];
  endfunction
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    comparisons++;
    if (seen !== exp) begin
      error_cnt++;
      $display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic conclude();
    $display("errors=%0d comparisons=%0d", error_cnt, comparisons);
    if (error_cnt == 0 && comparisons > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic sb(input logic [7:0] b);
    i_host.xb(b, 8);
  endtask
  task automatic op_a(input logic [7:0] op, input logic [23:0] a);
    i_host.open_f();
    sb(op);
    sb(a[23:16]);
    sb(a[15:8]);
    sb(a[7:0]);
  endtask
  task automatic wren();
    i_host.open_f();
    sb(OP_WREN);
    i_host.close_f();
  endtask
  task automatic wait_idle();
    int n;
    n = 0;
    while (status[0] !== 1'b0 && n < 40000) begin
      @(negedge clk);
      n++;
    end
    if (n == 40000) begin
      error_cnt++;
      conclude();
    end
  endtask
  task automatic wrsr(input logic [7:0] v);
    wren();
    i_host.open_f();
    sb(OP_WRSR);
    sb(v);
    i_host.close_f();
    wait_idle();
  endtask
  task automatic stat(input logic [7:0] e);
    exp_q = {e, e};
    i_host.open_f();
    sb(OP_RDSR);
    i_host.cap = 1'b1;
    sb(8'h00);
    sb(8'h00);
    i_host.cap = 1'b0;
    i_host.close_f();
  endtask
  task automatic rd(input logic [7:0] op, input logic [23:0] a, input int n);
    op_a(op, a);
    i_host.dual = (op == OP_DUAL);
    if (op != OP_READ) sb(rnd());
    i_host.cap = 1'b1;
    repeat (n) i_host.xb(8'h00, i_host.dual ? 4 : 8);
    i_host.cap = 1'b0;
    i_host.close_f();
    check({7'h00, so_oe | b_oe}, 8'h00);
    check(8'(exp_q.size()), 8'h00);
  endtask
  // An unexpected byte counts as a mismatch.
  always @(posedge clk) begin
    if (stb === 1'b1) begin
      if (exp_q.size() > 0) begin
        check(rxd, exp_q.pop_front());
      end else begin
        check(8'h01, 8'h00);
      end
    end
  end
  // ****
  // Main sequence.
  // ****
  initial begin
    write_protect_n = 1'b1;
    rst_n = 1'b0;
    repeat (8) @(negedge clk);
    rst_n = 1'b1;
    repeat (4) @(negedge clk);
    check(status, SR_RESET);
    wren();
    op_a(OP_BE32, 24'h004567);
    i_host.close_f();
    check(status, 8'h03);
    stat(8'h03);
    op_a(OP_READ, 24'h000000);
    sb(8'h00);
    check({7'h00, so_oe}, 8'h00);
    i_host.close_f();
    check(status, 8'h03);
    wait_idle();
    check(status, 8'h00);
    wren();
    op_a(OP_SE, 24'h009abc);
    i_host.close_f();
    check(status, 8'h03);
    wait_idle();
    exp_q = {ERASED};
    rd(OP_READ, 24'h009000, 1);
    wren();
    op_a(OP_PROG, 24'h0001fe);
    for (int i = 0; i < 258; i++) begin
      d[i] = rnd();
      sb(d[i]);
    end
    i_host.close_f();
    check(status, 8'h03);
    wait_idle();
    check(status, 8'h00);
    exp_q = {d[256], d[257], ERASED};
    rd(OP_READ, 24'h0001fe, 3);
    exp_q = {d[2], d[3]};
    rd(OP_FAST, 24'h000100, 2);
    exp_q = {ERASED, d[2]};
    rd(OP_DUAL, 24'h0000ff, 2);
    wren();
    op_a(OP_PROG, 24'h000010);
    sb(8'h00);
    i_host.xb(8'h00, 3);
    i_host.close_f();
    check(status, 8'h02);
    i_host.open_f();
    sb(OP_WRDI);
    i_host.close_f();
    op_a(OP_PROG, 24'h000011);
    sb(8'h00);
    i_host.close_f();
    check(status, 8'h00);
    op_a(OP_SE, 24'h000000);
    i_host.close_f();
    check(status, 8'h00);
    wrsr(8'hff);
    check(status, SR_WMASK);
    wren();
    op_a(OP_PROG, 24'h000012);
    sb(8'h00);
    i_host.close_f();
    check(status, 8'hbe);
    op_a(OP_BE64, 24'h000000);
    i_host.close_f();
    check(status, 8'hbe);
    write_protect_n = 1'b0;
    wrsr(8'h00);
    check(status, 8'hbe);
    write_protect_n = 1'b1;
    wrsr(8'h00);
    check(status, 8'h00);
    exp_q = {ERASED, ERASED, ERASED};
    rd(OP_READ, 24'h000010, 3);
    conclude();
  end
  initial begin
    repeat (100000) @(posedge clk);
    error_cnt++;
    conclude();
  end
endmodule // spf_flash_seq_test
